// ### hdl/ucm_pkg.sv
package ucm_pkg;
    localparam logic [7:0] OFS_MODE     = 8'h00;
    localparam logic [7:0] OFS_COMMAND  = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_HOLDING  = 8'h0C;
    localparam logic [7:0] OFS_AUX      = 8'h10;
    localparam logic [7:0] OFS_IN_CHG   = 8'h14;
    localparam logic [7:0] OFS_INT_STAT = 8'h18;
    localparam logic [7:0] OFS_INT_MASK = 8'h1C;
    localparam logic [7:0] OFS_CT_HIGH  = 8'h20;
    localparam logic [7:0] OFS_CT_LOW   = 8'h24;
    localparam logic [7:0] OFS_PIN_CFG  = 8'h28;
    localparam logic [7:0] OFS_OUT_SET  = 8'h2C;
    localparam logic [7:0] OFS_OUT_CLR  = 8'h30;
    localparam logic [7:0] OFS_OUT_BITS = 8'h34;

    localparam int MR1_RTS_CTRL = 7;
    localparam int MR1_IRQ_SEL  = 6;
    localparam int MR1_ERR_MODE = 5;
    localparam int MR1_PAR_LSB  = 3;
    localparam int MR1_PAR_TYPE = 2;
    localparam int MR2_STOP2    = 3;
    localparam int PIN_RX_IRQ   = 4;
    localparam int PIN_RTS      = 0;
    localparam logic [1:0] PAR_WITH  = 2'b00;
    localparam logic [1:0] PAR_FORCE = 2'b01;
    localparam logic [1:0] PAR_NONE  = 2'b10;
    localparam logic [1:0] PAR_MDROP = 2'b11;

    localparam logic [2:0] CMD_SET_PTR   = 3'h1;
    localparam logic [2:0] CMD_RST_RX    = 3'h2;
    localparam logic [2:0] CMD_RST_TX    = 3'h3;
    localparam logic [2:0] CMD_RST_ERR   = 3'h4;
    localparam logic [2:0] CMD_RST_BRKCH = 3'h5;

    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam int         FIFO_DEPTH = 4;

    localparam int CLK_HZ     = 125_000_000;
    localparam int BAUD_RATE  = 115_200;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
    localparam logic [11:0] BIT_CNT  = 12'(BIT_CYCLES - 1);
    localparam logic [11:0] HALF_CNT = 12'(BIT_CYCLES / 2 - 1);

    typedef struct packed {
        logic       brk;
        logic       framing_fault;
        logic       parity_fault;
        logic [7:0] data;
    } ucm_rx_entry_t;

    typedef enum logic [2:0] {
        LN_IDLE  = 3'b000,
        LN_START = 3'b001,
        LN_DATA  = 3'b011,
        LN_PAR   = 3'b010,
        LN_STOP  = 3'b110,
        LN_STOP2 = 3'b111
    } ucm_line_state_t;
endpackage

// ### hdl/ucm_channel.sv
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ucm_fifo #(
    parameter int W = 11,
    parameter int D = 4
) (
    input  wire logic         i_ref_clk,   // clock
    input  wire logic         i_reset,     // sync reset
    input  wire logic         i_in_valid,  // push request
    output logic              o_in_ready,  // room left
    input  wire logic [W-1:0] i_in_data,   // pushed word
    output logic              o_out_valid, // word at top
    input  wire logic         i_out_ready, // pop request
    output logic [W-1:0]      o_out_data   // top word
);
    localparam int AW = $clog2(D);
    logic [W-1:0]      mem [D];
    logic [AW-1:0]     wr_q;
    logic [AW-1:0]     rd_q;
    logic [AW:0]       cnt_q;
    logic              push;
    logic              pop;

    assign o_in_ready  = (cnt_q != (AW+1)'(D));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem[rd_q];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = i_out_ready && o_out_valid;

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module ucm_channel (
    input  wire logic        i_ref_clk,  // 125 MHz clock
    input  wire logic        i_reset,    // sync reset, active high
    input  wire logic        i_psel,     // apb select
    input  wire logic        i_penable,  // apb enable
    input  wire logic        i_pwrite,   // apb direction
    input  wire logic [7:0]  i_paddr,    // apb byte address
    input  wire logic [31:0] i_pwdata,   // apb write data
    output logic [31:0]      o_prdata,   // apb read data
    output logic             o_pready,   // apb ready
    output logic             o_pslverr,  // apb error, unmapped
    input  wire logic        i_rx_line,  // serial in
    output logic             o_tx_line,  // serial out
    input  wire logic [3:0]  i_in_port,  // watched inputs
    output logic [7:0]       o_out_pins, // output port pins, low true
    output logic             o_irq       // interrupt request
);
    import ucm_pkg::*;

    logic [7:0]      mode_one_q, mode_two_q, aux_q, mask_q, ct_hi_q, ct_lo_q;
    logic [7:0]      pin_cfg_q, out_bits_q;
    logic            ptr_two_q, rx_en_q, tx_en_q;
    logic [31:0]     prdata_q;
    logic            pslverr_q, irq_q;
    logic            setup, wr_acc, rd_acc;
    logic [7:0]      rd_mux;
    logic            mapped;
    logic [2:0]      cmd;
    logic [1:0]      par_mode;
    ucm_rx_entry_t   rx_entry, top;
    logic            fifo_push, fifo_room, fifo_valid, fifo_pop;
    ucm_line_state_t rx_st_q, tx_st_q;
    logic [11:0]     rx_cnt_q, tx_cnt_q;
    logic [2:0]      rx_idx_q, tx_idx_q;
    logic [7:0]      rx_shift_q, tx_shift_q, thr_q;
    logic            rx_par_q, thr_full_q, tx_line_q;
    logic            rts_hold_q, overrun_q, brk_seen_q, brk_delta_q;
    logic [2:0]      accum_q, err_bits;
    logic [3:0]      in_prev_q, in_delta_q;
    logic            rx_flag, tx_ready, tx_empty;
    logic [7:0]      int_stat;

    function automatic logic [2:0] last_idx(input logic [7:0] mr);
        return {1'b1, mr[1:0]};  // 5..8 data bits, index of last one
    endfunction

    function automatic logic par_bit(input logic [7:0] d, input logic [7:0] mr);
        logic [7:0] m;
        m = 8'hFF >> (3'd3 - {1'b0, mr[1:0]});
        if (mr[MR1_PAR_LSB +: 2] == PAR_WITH) begin
            return (^(d & m)) ^ mr[MR1_PAR_TYPE];
        end
        return mr[MR1_PAR_TYPE];
    endfunction

    assign cmd      = i_pwdata[6:4];
    assign par_mode = mode_one_q[MR1_PAR_LSB +: 2];
    assign setup    = i_psel && !i_penable;
    assign wr_acc   = i_psel && i_penable && i_pwrite;
    assign rd_acc   = i_psel && i_penable && !i_pwrite;
    assign o_pready = i_psel && i_penable;
    assign o_prdata = prdata_q;
    assign o_pslverr = pslverr_q;
    assign o_tx_line = tx_line_q;
    assign o_irq    = irq_q;

    // channel B and the counter live elsewhere, their status bits read zero
    assign rx_flag  = mode_one_q[MR1_IRQ_SEL] ? !fifo_room : fifo_valid;
    assign tx_ready = tx_en_q && !thr_full_q;
    assign tx_empty = tx_ready && (tx_st_q == LN_IDLE);
    assign int_stat = {|(in_delta_q & aux_q[3:0]), 3'b000, 1'b0,
                       brk_delta_q, rx_flag, tx_ready};
    assign err_bits = mode_one_q[MR1_ERR_MODE] ? accum_q :
                      (fifo_valid ? {top.brk, top.framing_fault, top.parity_fault} : 3'b000);

    always_comb begin
        mapped = 1'b1;
        rd_mux = 8'h00;
        case (i_paddr)
            OFS_MODE:     rd_mux = ptr_two_q ? mode_two_q : mode_one_q;
            OFS_STATUS:   rd_mux = {err_bits, overrun_q, tx_empty, tx_ready,
                                    !fifo_room, fifo_valid};
            OFS_HOLDING:  rd_mux = top.data;
            OFS_IN_CHG:   rd_mux = {in_delta_q, i_in_port};
            OFS_INT_STAT: rd_mux = int_stat;
            OFS_OUT_BITS: rd_mux = out_bits_q;
            OFS_COMMAND, OFS_AUX, OFS_INT_MASK, OFS_CT_HIGH, OFS_CT_LOW,
            OFS_PIN_CFG, OFS_OUT_SET, OFS_OUT_CLR: rd_mux = 8'h00;
            default:      mapped = 1'b0;
        endcase
    end

    // read data is sampled in the setup cycle so the slave answers with no wait
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q  <= {24'h00_0000, rd_mux};
            pslverr_q <= !mapped;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            ptr_two_q <= 1'b0;
        end else if (wr_acc && i_paddr == OFS_COMMAND && cmd == CMD_SET_PTR) begin
            ptr_two_q <= 1'b0;
        end else if ((wr_acc || rd_acc) && i_paddr == OFS_MODE) begin
            ptr_two_q <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            mode_one_q <= MODE_RESET;
            mode_two_q <= MODE_RESET;
            aux_q      <= REG_RESET;
            mask_q     <= REG_RESET;
            ct_hi_q    <= REG_RESET;
            ct_lo_q    <= REG_RESET;
            pin_cfg_q  <= REG_RESET;
            out_bits_q <= REG_RESET;
            rx_en_q    <= 1'b0;
            tx_en_q    <= 1'b0;
        end else if (wr_acc) begin
            case (i_paddr)
                OFS_MODE: begin
                    if (ptr_two_q) begin
                        mode_two_q <= i_pwdata[7:0];
                    end else begin
                        mode_one_q <= i_pwdata[7:0];
                    end
                end
                OFS_COMMAND: begin
                    if (i_pwdata[0]) rx_en_q <= 1'b1;
                    if (i_pwdata[1]) rx_en_q <= 1'b0;
                    if (i_pwdata[2]) tx_en_q <= 1'b1;
                    if (i_pwdata[3]) tx_en_q <= 1'b0;
                    if (cmd == CMD_RST_RX) rx_en_q <= 1'b0;
                    if (cmd == CMD_RST_TX) tx_en_q <= 1'b0;
                end
                OFS_AUX:      aux_q      <= i_pwdata[7:0];
                OFS_INT_MASK: mask_q     <= i_pwdata[7:0];
                OFS_CT_HIGH:  ct_hi_q    <= i_pwdata[7:0];
                OFS_CT_LOW:   ct_lo_q    <= i_pwdata[7:0];
                OFS_PIN_CFG:  pin_cfg_q  <= i_pwdata[7:0];
                OFS_OUT_SET:  out_bits_q <= out_bits_q | i_pwdata[7:0];
                OFS_OUT_CLR:  out_bits_q <= out_bits_q & ~i_pwdata[7:0];
                default: ;
            endcase
        end
    end

    // receiver: one bit counter, sampled at mid-bit
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || (wr_acc && i_paddr == OFS_COMMAND && cmd == CMD_RST_RX)) begin
            rx_st_q    <= LN_IDLE;
            rx_cnt_q   <= 12'h000;
            rx_idx_q   <= 3'h0;
            rx_shift_q <= 8'h00;
            rx_par_q   <= 1'b0;
            fifo_push  <= 1'b0;
            rx_entry   <= '0;
        end else begin
            fifo_push <= 1'b0;
            rx_cnt_q  <= (rx_cnt_q == 12'h000) ? BIT_CNT : rx_cnt_q - 12'h001;
            case (rx_st_q)
                LN_IDLE: begin
                    if (rx_en_q && !i_rx_line) begin
                        rx_st_q  <= LN_START;
                        rx_cnt_q <= HALF_CNT;
                    end
                end
                LN_START: begin
                    if (rx_cnt_q == 12'h000) begin
                        rx_st_q    <= i_rx_line ? LN_IDLE : LN_DATA;
                        rx_idx_q   <= 3'h0;
                        rx_shift_q <= 8'h00;
                        rx_par_q   <= 1'b0;
                    end
                end
                LN_DATA: begin
                    if (rx_cnt_q == 12'h000) begin
                        rx_shift_q[rx_idx_q] <= i_rx_line;
                        rx_idx_q <= rx_idx_q + 3'h1;
                        if (rx_idx_q == last_idx(mode_one_q)) begin
                            rx_st_q <= (par_mode == PAR_NONE) ? LN_STOP : LN_PAR;
                        end
                    end
                end
                LN_PAR: begin
                    if (rx_cnt_q == 12'h000) begin
                        rx_par_q <= i_rx_line;
                        rx_st_q  <= LN_STOP;
                    end
                end
                default: begin
                    if (rx_cnt_q == 12'h000) begin
                        fifo_push              <= 1'b1;
                        rx_entry.data          <= rx_shift_q;
                        rx_entry.framing_fault <= !i_rx_line;
                        rx_entry.brk           <= !i_rx_line && rx_shift_q == 8'h00 && !rx_par_q;
                        // multidrop keeps the address/data flag in the parity slot
                        rx_entry.parity_fault  <= (par_mode == PAR_MDROP) ? rx_par_q :
                            (rx_par_q != par_bit(rx_shift_q, mode_one_q));
                        rx_st_q <= LN_IDLE;
                    end
                end
            endcase
        end
    end

    assign fifo_pop = rd_acc && i_paddr == OFS_HOLDING;

    ucm_fifo #(.W($bits(ucm_rx_entry_t)), .D(FIFO_DEPTH)) u_rx_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_reset     (i_reset),
        .i_in_valid  (fifo_push),
        .o_in_ready  (fifo_room),
        .i_in_data   (rx_entry),
        .o_out_valid (fifo_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  (top)
    );

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            rts_hold_q <= 1'b0;
        end else if (mode_one_q[MR1_RTS_CTRL] && rx_st_q == LN_START
                     && rx_cnt_q == 12'h000 && !i_rx_line && !fifo_room) begin
            rts_hold_q <= 1'b1;
        end else if (fifo_room) begin
            rts_hold_q <= 1'b0;
        end
    end

    // the accumulators let a new set win over a clear in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            accum_q     <= 3'b000;
            overrun_q   <= 1'b0;
            brk_seen_q  <= 1'b0;
            brk_delta_q <= 1'b0;
            in_prev_q   <= 4'h0;
            in_delta_q  <= 4'h0;
        end else begin
            accum_q   <= ((wr_acc && i_paddr == OFS_COMMAND && cmd == CMD_RST_ERR) ? 3'b000
                          : accum_q)
                         | (fifo_valid ? {top.brk, top.framing_fault, top.parity_fault}
                            : 3'b000);
            overrun_q <= ((wr_acc && i_paddr == OFS_COMMAND && cmd == CMD_RST_ERR) ? 1'b0
                          : overrun_q) | (fifo_push && !fifo_room);
            if (fifo_push) begin
                brk_seen_q <= rx_entry.brk;
            end
            brk_delta_q <= ((wr_acc && i_paddr == OFS_COMMAND && cmd == CMD_RST_BRKCH) ? 1'b0
                            : brk_delta_q) | (fifo_push && rx_entry.brk != brk_seen_q);
            in_prev_q  <= i_in_port;
            in_delta_q <= ((rd_acc && i_paddr == OFS_IN_CHG) ? 4'h0 : in_delta_q)
                          | (in_prev_q ^ i_in_port);
        end
    end

    // transmitter with a single holding register
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || (wr_acc && i_paddr == OFS_COMMAND && cmd == CMD_RST_TX)) begin
            tx_st_q    <= LN_IDLE;
            tx_cnt_q   <= 12'h000;
            tx_idx_q   <= 3'h0;
            tx_shift_q <= 8'h00;
            thr_q      <= 8'h00;
            thr_full_q <= 1'b0;
            tx_line_q  <= 1'b1;
        end else begin
            tx_cnt_q <= (tx_cnt_q == 12'h000) ? BIT_CNT : tx_cnt_q - 12'h001;
            if (wr_acc && i_paddr == OFS_HOLDING && tx_ready) begin
                thr_q      <= i_pwdata[7:0];
                thr_full_q <= 1'b1;
            end
            case (tx_st_q)
                LN_IDLE: begin
                    tx_line_q <= 1'b1;
                    if (thr_full_q) begin
                        tx_shift_q <= thr_q;
                        thr_full_q <= 1'b0;
                        tx_line_q  <= 1'b0;
                        tx_cnt_q   <= BIT_CNT;
                        tx_idx_q   <= 3'h0;
                        tx_st_q    <= LN_DATA;
                    end
                end
                LN_DATA: begin
                    if (tx_cnt_q == 12'h000) begin
                        tx_line_q <= tx_shift_q[tx_idx_q];
                        tx_idx_q  <= tx_idx_q + 3'h1;
                        if (tx_idx_q == last_idx(mode_one_q)) begin
                            tx_st_q <= (par_mode == PAR_NONE) ? LN_STOP : LN_PAR;
                        end
                    end
                end
                LN_PAR: begin
                    if (tx_cnt_q == 12'h000) begin
                        tx_line_q <= par_bit(tx_shift_q, mode_one_q);
                        tx_st_q   <= LN_STOP;
                    end
                end
                LN_STOP: begin
                    if (tx_cnt_q == 12'h000) begin
                        tx_line_q <= 1'b1;
                        tx_st_q   <= mode_two_q[MR2_STOP2] ? LN_STOP2 : LN_START;
                    end
                end
                LN_STOP2: begin
                    if (tx_cnt_q == 12'h000) begin
                        tx_st_q <= LN_START;
                    end
                end
                default: begin
                    // LN_START here marks the last stop bit on the line
                    if (tx_cnt_q == 12'h000) begin
                        tx_st_q <= LN_IDLE;
                    end
                end
            endcase
        end
    end

    // pins are low true: a set output bit drives its pin low, except PIN_RTS under rts_hold_q and PIN_RX_IRQ under pin_cfg_q
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_out_pins <= 8'hFF;
            irq_q      <= 1'b0;
        end else begin
            o_out_pins <= ~out_bits_q;
            o_out_pins[PIN_RTS] <= !(out_bits_q[PIN_RTS] && !rts_hold_q);
            if (pin_cfg_q[PIN_RX_IRQ]) begin
                o_out_pins[PIN_RX_IRQ] <= !rx_flag;
            end
            irq_q <= |(int_stat & mask_q);
        end
    end
endmodule

`default_nettype wire

// ### test/ucm_channel_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ucm_channel_sva (
    input wire logic        i_ref_clk,  // clock
    input wire logic        i_reset,    // sync reset
    input wire logic        i_psel,     // apb select
    input wire logic        i_penable,  // apb enable
    input wire logic        i_pwrite,   // apb direction
    input wire logic [7:0]  i_paddr,    // apb address
    input wire logic [31:0] i_pwdata,   // apb write data
    input wire logic [31:0] o_prdata,   // apb read data
    input wire logic        o_pready,   // apb ready
    input wire logic        o_pslverr,  // apb error
    input wire logic        o_tx_line,  // serial out
    input wire logic [7:0]  o_out_pins, // output pins
    input wire logic        o_irq       // interrupt
);
    import ucm_pkg::*;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    sequence acc_s;
        i_psel && i_penable;
    endsequence
    sequence wr_s(logic [7:0] a);
        acc_s ##0 i_pwrite && i_paddr == a;
    endsequence
    ready_now_a: assert property (acc_s |-> o_pready) else $error("no ready in access");
    bad_addr_a: assert property (acc_s ##0 i_paddr > OFS_OUT_BITS |-> o_pslverr)
        else $error("unmapped address not refused");
    good_addr_a: assert property (acc_s ##0 i_paddr <= OFS_OUT_BITS && i_paddr[1:0] == 2'b00
        |-> !o_pslverr) else $error("mapped address refused");
    refused_zero_a: assert property (acc_s ##0 o_pslverr |-> o_prdata == 32'h0)
        else $error("refused read carries data");
    upper_zero_a: assert property (acc_s |-> o_prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    reset_idle_a: assert property ($fell(i_reset) |-> o_tx_line && o_out_pins == 8'hFF && !o_irq)
        else $error("outputs not idle after reset");
    // the pin register follows the output bit one cycle after the write lands
    rts_clear_a: assert property (wr_s(OFS_OUT_CLR) ##0 i_pwdata[0]
        |=> ##1 o_out_pins[PIN_RTS]) else $error("rts pin still asserted after clear");
    mask_off_a: assert property (wr_s(OFS_INT_MASK) ##0 i_pwdata[7:0] == 8'h00 |=> ##1 !o_irq)
        else $error("irq with all masked");
    start_bit_a: assert property ($fell(o_tx_line) |-> !o_tx_line [*8])
        else $error("start bit too short");
endmodule
bind ucm_channel ucm_channel_sva u_sva (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_tx_line(o_tx_line),
    .o_out_pins(o_out_pins), .o_irq(o_irq)
);
`default_nettype wire

// ### test/ucm_remote_tx.sv
`timescale 1ns/1ps
`default_nettype none
module ucm_remote_tx (
    input  wire logic       i_ref_clk, // clock
    input  wire logic       i_send,    // frame request
    input  wire logic [9:0] i_bits,    // bits after start, lsb first
    input  wire logic       i_cts_n,   // clear to send, low true
    output logic            o_line,    // serial line, idle high
    output logic            o_busy     // frame in flight
);
    import ucm_pkg::*;
    initial begin
        o_line = 1'b1;
        o_busy = 1'b0;
    end
    // clear-to-send is looked at only before a frame, never inside one
    always begin
        @(posedge i_ref_clk);
        if (i_send && i_cts_n === 1'b0) begin
            o_busy <= 1'b1;
            o_line <= 1'b0;
            for (int k = 0; k < 10; k++) begin
                repeat (BIT_CYCLES) @(posedge i_ref_clk);
                o_line <= i_bits[k];
            end
            repeat (BIT_CYCLES) @(posedge i_ref_clk);
            o_busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### test/tb_ucm_channel.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ucm_channel;
    import ucm_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        perr;
    logic        rx_line;
    logic        tx_line;
    logic [3:0]  in_port = 4'h0;
    logic [7:0]  pins;
    logic        irq;
    logic        rx_send = 1'b0;
    logic [9:0]  rx_bits = 10'h3FF;
    logic        rx_busy;
    logic [31:0] r;
    logic        err;
    logic [7:0]  wo [4] = '{OFS_AUX, OFS_INT_MASK, OFS_CT_HIGH, OFS_CT_LOW};
    int          error_cnt = 0;
    int          num_checks = 0;
    int          cyc = 0;
    ucm_channel uut (
        .i_ref_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(perr), .i_rx_line(rx_line),
        .o_tx_line(tx_line), .i_in_port(in_port), .o_out_pins(pins), .o_irq(irq)
    );
    ucm_remote_tx far (
        .i_ref_clk(clk), .i_send(rx_send), .i_bits(rx_bits),
        .i_cts_n(pins[PIN_RTS]), .o_line(rx_line), .o_busy(rx_busy)
    );
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        // returns in the edge's time step: reads see what the previous edge launched
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    // parity bit is even unless a bad frame is asked for
    task automatic send(input logic [7:0] d, input logic bad, input logic wait_end);
        rx_bits <= {1'b1, ^d ^ bad, d};
        rx_send <= 1'b1;
        while (rx_busy !== 1'b1) @(posedge clk);
        rx_send <= 1'b0;
        while (wait_end && rx_busy !== 1'b0) @(posedge clk);
    endtask
    task automatic t_ptr;
        apb(1'b1, OFS_MODE, 8'hE3);
        apb(1'b1, OFS_MODE, 8'h00);
        apb(1'b0, OFS_MODE, 8'h00);
        check(r, 32'h00);
        apb(1'b1, OFS_COMMAND, {1'b0, CMD_SET_PTR, 4'h0});
        apb(1'b0, OFS_MODE, 8'h00);
        check(r, 32'hE3);
        apb(1'b0, OFS_MODE, 8'h00);
        check(r, 32'h00);
    endtask
    task automatic t_regs;
        apb(1'b0, 8'h3C, 8'h00);
        check({r[30:0], err}, 32'h1);
        foreach (wo[i]) begin
            apb(1'b1, wo[i], 8'h5A);
            apb(1'b0, wo[i], 8'h00);
            check(r, 32'h0);
        end
    endtask
    task automatic t_inp;
        in_port <= 4'hA;
        tick(8);
        apb(1'b0, OFS_IN_CHG, 8'h00);
        check(r, 32'hAA);
        apb(1'b0, OFS_IN_CHG, 8'h00);
        check(r, 32'h0A);
        apb(1'b1, OFS_AUX, 8'h0F);
        apb(1'b1, OFS_INT_MASK, 8'h80);
        in_port <= 4'h3;
        tick(8);
        apb(1'b0, OFS_INT_STAT, 8'h00);
        check({r[7], irq}, 2'b11);
        // mask off while the change flag still stands, so only the mask can drop irq
        apb(1'b1, OFS_INT_MASK, 8'h00);
        tick(2);
        check(irq, 1'b0);
        apb(1'b0, OFS_IN_CHG, 8'h00);
        check(r, 32'h93);
    endtask
    task automatic t_rx;
        apb(1'b1, OFS_COMMAND, 8'h01);
        apb(1'b1, OFS_PIN_CFG, 8'h10);
        apb(1'b1, OFS_OUT_SET, 8'h01);
        apb(1'b1, OFS_INT_MASK, 8'h02);
        tick(2);
        check(pins[PIN_RTS], 1'b0);
        for (int k = 0; k < 4; k++) send(8'h50 + 8'(k), k == 1, 1'b1);
        tick(2);
        check({irq, pins[PIN_RX_IRQ]}, 2'b10);
        apb(1'b0, OFS_STATUS, 8'h00);
        check({r[5], r[1:0]}, 3'b011);
        send(8'h54, 1'b0, 1'b0);
        tick(700);
        check(pins[PIN_RTS], 1'b1);
        apb(1'b0, OFS_HOLDING, 8'h00);
        check(r, 32'h50);
        tick(2);
        check({pins[PIN_RTS], pins[PIN_RX_IRQ]}, 2'b01);
        apb(1'b0, OFS_STATUS, 8'h00);
        check(r[5], 1'b1);
        apb(1'b0, OFS_HOLDING, 8'h00);
        apb(1'b0, OFS_STATUS, 8'h00);
        check(r[5], 1'b1);
        apb(1'b1, OFS_COMMAND, {1'b0, CMD_SET_PTR, 4'h0});
        apb(1'b1, OFS_MODE, 8'hC3);
        apb(1'b0, OFS_STATUS, 8'h00);
        check(r[5], 1'b0);
        apb(1'b1, OFS_COMMAND, {1'b0, CMD_SET_PTR, 4'h0});
        apb(1'b1, OFS_MODE, 8'hE3);
        apb(1'b1, OFS_COMMAND, {1'b0, CMD_RST_ERR, 4'h0});
        apb(1'b0, OFS_STATUS, 8'h00);
        check(r[5], 1'b0);
        while (rx_busy !== 1'b0) @(posedge clk);
        apb(1'b1, OFS_OUT_CLR, 8'h01);
        tick(2);
        check(pins[PIN_RTS], 1'b1);
    endtask
    task automatic t_tx;
        logic [10:0] f;
        f = {1'b1, ^8'hA5, 8'hA5, 1'b0};
        apb(1'b1, OFS_COMMAND, 8'h04);
        apb(1'b1, OFS_HOLDING, 8'hA5);
        while (tx_line !== 1'b0) @(posedge clk);
        tick(543);
        for (int k = 0; k < 11; k++) begin
            check(tx_line, f[k]);
            tick(1085);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        t_ptr();
        t_regs();
        t_inp();
        t_rx();
        t_tx();
        final_report();
    end
endmodule
`default_nettype wire
